// *** lts_cfg.svh ***
`ifndef LTS_CFG_SVH
`define LTS_CFG_SVH

// Storage and list geometry
`define LTS_MAX_POINTS 100
`define LTS_GEN1_MAX_POINTS 32
`define LTS_NLISTS 7
`define LTS_IDX_W 7
`define LTS_LEN_W 8
`define LTS_DATA_W 32

// Value ranges
`define LTS_PASS_W 28
`define LTS_PASS_MIN 28'h0000001
`define LTS_PASS_MAX 28'hbebc200
`define LTS_DWELL_W 27
`define LTS_DWELL_MIN_MS 27'h0000001
`define LTS_DWELL_MAX_MS 27'h55d4a80
`define LTS_REP_W 7
`define LTS_REPEAT_MAX 7'h63
`define LTS_SLEW_INSTANT 32'hffffffff

// Timing: dwell resolution is 0.001 s
`define LTS_CLK_PERIOD_NS 100
`define LTS_DWELL_UNIT_NS 1000000
`define LTS_TICK_CYCLES (`LTS_DWELL_UNIT_NS / `LTS_CLK_PERIOD_NS)

// Bit positions in the function list-mode mask
`define LTS_FN_FREQ 0
`define LTS_FN_SLEW 1
`define LTS_FN_SHAPE 2
`define LTS_FN_VOLT 3
`define LTS_FN_W 4

`endif

// *** lts_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lts_ctl_model
  import lts_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Requests toward the sequencer
  output logic wr_en,
  output lts_list_type wr_list,
  output logic [6:0] wr_index,
  output logic [31:0] wr_data,
  output logic wr_last,
  output logic trigger
);
  initial begin
    wr_en = 1'b0;
    wr_list = LST_FREQ;
    wr_index = 7'h7f;
    wr_data = 32'h0;
    wr_last = 1'b0;
    trigger = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released index and data lines show the inverse so stale values are never mistaken for data
  task automatic put(input lts_list_type l, input logic [6:0] i, input logic [31:0] d,
                     input logic last);
    @(posedge core_clk);
    wr_en <= 1'b1;
    wr_list <= l;
    wr_index <= i;
    wr_data <= d;
    wr_last <= last;
    @(posedge core_clk);
    wr_en <= 1'b0;
    wr_last <= 1'b0;
    wr_index <= ~i;
    wr_data <= ~d;
  endtask : put

  // Whole list in supplied order, length set on the final entry
  task automatic put_list(input lts_list_type l, input int n, input logic [31:0] a,
                          input logic [31:0] b, input logic [31:0] c);
    put(l, 7'h0, a, n == 1);
    if (n > 1) put(l, 7'h1, b, n == 2);
    if (n > 2) put(l, 7'h2, c, 1'b1);
  endtask : put_list

  task automatic trig();
    @(posedge core_clk);
    trigger <= 1'b1;
    @(posedge core_clk);
    trigger <= 1'b0;
  endtask : trig
endmodule : lts_ctl_model
`default_nettype wire

// *** lts_dwell_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lts_cfg.svh"
module lts_dwell_timer #(
  parameter int TICK_CYCLES = `LTS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [`LTS_DWELL_W-1:0] dwell_ms,
  // Status
  output logic expired
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  logic run_q;
  logic [PW-1:0] pre_q;
  logic [`LTS_DWELL_W-1:0] ms_q;
  logic expired_q;

  // Out-of-range dwell values are pulled into the legal window
  wire too_small = dwell_ms < `LTS_DWELL_MIN_MS;
  wire too_big = dwell_ms > `LTS_DWELL_MAX_MS;
  wire [`LTS_DWELL_W-1:0] dwell_lim = too_small ? `LTS_DWELL_MIN_MS :
                                      (too_big ? `LTS_DWELL_MAX_MS : dwell_ms);
  wire tick = run_q && (pre_q == PW'(TICK_CYCLES - 1));
  wire last_tick = tick && (ms_q == `LTS_DWELL_MIN_MS);

  // One millisecond per prescaler wrap
  always_ff @(posedge core_clk) begin
    if (!reset_n || abort) begin
      run_q <= 1'b0;
      pre_q <= '0;
      ms_q <= '0;
    end else if (start) begin
      // Starting one count in absorbs the registered expiry, so the dwell is exactly D ticks
      run_q <= 1'b1;
      pre_q <= PW'(1);
      ms_q <= dwell_lim;
    end else if (run_q) begin
      pre_q <= tick ? '0 : pre_q + 1'b1;
      if (tick) begin
        ms_q <= ms_q - 1'b1;
      end
      if (last_tick) begin
        run_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= last_tick && !abort;
    end
  end

  assign expired = expired_q;

endmodule : lts_dwell_timer
`default_nettype wire

// *** lts_pkg.sv ***
`include "lts_cfg.svh"
package lts_pkg;

  typedef enum logic [2:0] {
    LST_FREQ = 3'h0,
    LST_SLEW = 3'h1,
    LST_SHAPE = 3'h2,
    LST_VOLT = 3'h3,
    LST_DWELL = 3'h4,
    LST_REPEAT = 3'h5,
    LST_MARKER = 3'h6
  } lts_list_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOAD = 5'h02,
    ST_DWELL = 5'h04,
    ST_HOLD = 5'h08,
    ST_DONE = 5'h10
  } lts_state_type;

  typedef struct packed {
    logic [31:0] freq;
    logic [31:0] slew;
    logic [15:0] volt;
    logic [3:0] shape;
  } lts_point_type;

endpackage : lts_pkg

// *** lts_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lts_cfg.svh"
module lts_sequencer
  import lts_pkg::*;
#(
  parameter int TICK_CYCLES = `LTS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // List loading
  input wire logic wr_en,
  input wire lts_list_type wr_list,
  input wire logic [`LTS_IDX_W-1:0] wr_index,
  input wire logic [`LTS_DATA_W-1:0] wr_data,
  input wire logic wr_last,
  // Length query
  input wire lts_list_type len_sel,
  output logic [`LTS_LEN_W-1:0] len_out_q,
  // Control
  input wire logic [`LTS_FN_W-1:0] fn_list_mode,
  input wire logic single_advance,
  input wire logic [`LTS_PASS_W-1:0] pass_total,
  input wire logic trigger,
  // Output point
  output lts_point_type out_point_q,
  output logic [`LTS_FN_W-1:0] out_apply_q,
  output logic [`LTS_IDX_W-1:0] point_index_q,
  output logic marker_pulse_q,
  // Status
  output logic busy_q,
  output logic done_q,
  output logic list_error_q
);

  localparam int NL = `LTS_NLISTS;

  ////////////////////////////////////////////////////////////////////////////
  // List storage

  logic [`LTS_DATA_W-1:0] rd [NL];
  logic [`LTS_LEN_W-1:0] len [NL];
  logic [NL-1:0] act;
  logic [`LTS_IDX_W-1:0] idx_q;
  logic [`LTS_IDX_W-1:0] idx_d;
  wire any_list = |fn_list_mode;

  for (genvar i = 0; i < NL; i++) begin : g_list
    logic [`LTS_DATA_W-1:0] mem [`LTS_MAX_POINTS];
    logic [`LTS_LEN_W-1:0] len_q;
    wire hit = wr_en && (wr_list == lts_list_type'(i)) &&
               (wr_index < `LTS_IDX_W'(`LTS_MAX_POINTS));
    // Entries land at the index the controller gave them
    always_ff @(posedge core_clk) begin
      if (hit) begin
        mem[wr_index] <= wr_data;
      end
    end
    always_ff @(posedge core_clk) begin
      if (!reset_n) begin
        len_q <= '0;
      end else if (hit && wr_last) begin
        len_q <= `LTS_LEN_W'(wr_index) + 8'h01;
      end
    end
    // A one-point list is read at entry 0 whatever the step
    wire [`LTS_IDX_W-1:0] eidx = (len_q == 8'h01) ? '0 : idx_q;
    assign rd[i] = (len_q == 8'h00) ? '0 : mem[eidx];
    assign len[i] = len_q;
    if (i < `LTS_FN_W) begin : g_fn
      assign act[i] = fn_list_mode[i];
    end else if (i == int'(LST_DWELL)) begin : g_dw
      assign act[i] = any_list;
    end else begin : g_opt
      assign act[i] = any_list && (len_q != 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Length check

  logic [`LTS_LEN_W-1:0] target;
  logic [NL-1:0] len_bad;

  always_comb begin
    target = 8'h00;
    for (int k = 0; k < NL; k++) begin
      if (act[k] && (len[k] > target)) begin
        target = len[k];
      end
    end
  end

  // Every active list must be one point or the common length
  for (genvar j = 0; j < NL; j++) begin : g_chk
    assign len_bad[j] = act[j] &&
                        ((len[j] == 8'h00) || ((len[j] != 8'h01) && (len[j] != target)));
  end
  wire list_fault = |len_bad;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  lts_state_type state_q;
  lts_state_type state_d;
  logic [`LTS_REP_W-1:0] rep_q;
  logic [`LTS_REP_W-1:0] rep_d;
  logic [`LTS_PASS_W-1:0] pass_q;
  logic [`LTS_PASS_W-1:0] pass_d;
  logic [`LTS_PASS_W-1:0] goal_q;
  logic [`LTS_LEN_W-1:0] tgt_q;
  logic fresh_q;
  logic fresh_d;
  logic expired;

  wire running = (state_q == ST_LOAD) || (state_q == ST_DWELL) || (state_q == ST_HOLD);
  wire at_rest = (state_q == ST_IDLE) || (state_q == ST_DONE);
  // Loading a list mid-run kills the transient
  wire abort = wr_en && running;
  wire trig_start = trigger && any_list && at_rest && !wr_en;
  wire start_ok = trig_start && !list_fault;
  wire last_rep = (rep_q == 7'h00);
  wire last_pt = (`LTS_LEN_W'(idx_q) + 8'h01) >= tgt_q;
  wire last_pass = (pass_q + 1'b1) >= goal_q;
  wire finish = (state_q == ST_DWELL) && expired && last_rep && last_pt && last_pass;
  wire in_load = (state_q == ST_LOAD);
  wire [`LTS_REP_W-1:0] rd_rep = rd[LST_REPEAT][`LTS_REP_W-1:0];
  wire [`LTS_REP_W-1:0] rep_lim = (rd_rep > `LTS_REPEAT_MAX) ? `LTS_REPEAT_MAX : rd_rep;
  wire [`LTS_PASS_W-1:0] goal_lim = (pass_total < `LTS_PASS_MIN) ? `LTS_PASS_MIN :
                                    ((pass_total > `LTS_PASS_MAX) ? `LTS_PASS_MAX : pass_total);
  wire rd_mark = rd[LST_MARKER][0];

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    rep_d = rep_q;
    pass_d = pass_q;
    fresh_d = fresh_q;
    case (state_q)
      ST_IDLE, ST_DONE: begin
        if (start_ok) begin
          state_d = ST_LOAD;
          idx_d = '0;
          pass_d = '0;
          fresh_d = 1'b1;
        end
      end
      ST_LOAD: begin
        state_d = ST_DWELL;
        if (fresh_q) begin
          rep_d = rep_lim;
        end
      end
      ST_DWELL: begin
        // Triggers are not looked at here, so they are dropped
        if (expired) begin
          if (!last_rep) begin
            rep_d = rep_q - 1'b1;
            fresh_d = 1'b0;
          end else if (last_pt) begin
            idx_d = '0;
            pass_d = pass_q + 1'b1;
            fresh_d = 1'b1;
          end else begin
            idx_d = idx_q + 1'b1;
            fresh_d = 1'b1;
          end
          if (finish) begin
            state_d = ST_DONE;
          end else if (single_advance) begin
            state_d = ST_HOLD;
          end else begin
            state_d = ST_LOAD;
          end
        end
      end
      ST_HOLD: begin
        if (trigger) begin
          state_d = ST_LOAD;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (abort) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      idx_q <= '0;
      rep_q <= '0;
      pass_q <= '0;
      fresh_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      rep_q <= rep_d;
      pass_q <= pass_d;
      fresh_q <= fresh_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      goal_q <= `LTS_PASS_MIN;
      tgt_q <= 8'h00;
    end else if (start_ok) begin
      goal_q <= goal_lim;
      tgt_q <= target;
    end
  end

  // Each point, repeats included, restarts the dwell
  lts_dwell_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(in_load),
    .abort(abort),
    .dwell_ms(rd[LST_DWELL][`LTS_DWELL_W-1:0]),
    .expired(expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // The point and index outputs only change in the load cycle, so the last point stays after the end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      out_point_q <= '0;
      point_index_q <= '0;
    end else if (in_load) begin
      out_point_q.freq <= rd[LST_FREQ];
      out_point_q.slew <= rd[LST_SLEW];
      out_point_q.volt <= rd[LST_VOLT][15:0];
      out_point_q.shape <= rd[LST_SHAPE][3:0];
      point_index_q <= idx_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      out_apply_q <= '0;
      marker_pulse_q <= 1'b0;
      busy_q <= 1'b0;
      len_out_q <= '0;
    end else begin
      if (start_ok) begin
        out_apply_q <= fn_list_mode;
      end
      marker_pulse_q <= in_load && rd_mark;
      busy_q <= (state_d == ST_LOAD) || (state_d == ST_DWELL) || (state_d == ST_HOLD);
      len_out_q <= len[len_sel];
    end
  end

  // A trigger that passes the length check clears the done flag, since that trigger restarts
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      list_error_q <= 1'b0;
    end else begin
      if (finish && !abort) begin
        done_q <= 1'b1;
      end else if (start_ok || abort) begin
        done_q <= 1'b0;
      end
      if (trig_start && list_fault) begin
        list_error_q <= 1'b1;
      end else if (start_ok) begin
        list_error_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_reload;
    (state_q == ST_LOAD) ##1 (state_q == ST_DWELL);
  endsequence

  property p_pass_end;
    finish && !abort |=> (state_q == ST_DONE) && done_q && !busy_q;
  endproperty
  a_pass_end: assert property (p_pass_end) else $error("list did not end");

  property p_repeat_stay;
    (state_q == ST_DWELL) && expired && !last_rep && !abort |=> $stable(idx_q);
  endproperty
  a_repeat_stay: assert property (p_repeat_stay) else $error("repeat moved index");

  property p_fault_error;
    trig_start && list_fault |=> list_error_q && !busy_q;
  endproperty
  a_fault_error: assert property (p_fault_error) else $error("length fault missed");

  property p_auto_next;
    (state_q == ST_DWELL) && expired && !finish && !single_advance && !abort |=> s_reload;
  endproperty
  a_auto_next: assert property (p_auto_next) else $error("auto advance late");

  property p_single_hold;
    (state_q == ST_DWELL) && expired && !finish && single_advance && !abort
      |=> (state_q == ST_HOLD);
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("single mode ran on");

  property p_len_query;
    ##1 len_out_q == $past(len[len_sel]);
  endproperty
  a_len_query: assert property (p_len_query) else $error("length query wrong");

  property p_trig_drop;
    (state_q == ST_DWELL) && !expired && !wr_en |=> (state_q == ST_DWELL) && $stable(idx_q);
  endproperty
  a_trig_drop: assert property (p_trig_drop) else $error("dwell left early");

  property p_marker;
    in_load |=> (marker_pulse_q == $past(rd_mark));
  endproperty
  a_marker: assert property (p_marker) else $error("marker pulse wrong");

  property p_abort;
    abort |=> (state_q == ST_IDLE) ##1 !busy_q;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_done_hold;
    done_q && !trigger && !wr_en |=> done_q && $stable(out_point_q);
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done state lost");

endmodule : lts_sequencer
`default_nettype wire

// *** lts_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module lts_sequencer_tb_top;
  import lts_pkg::*;
  logic core_clk;
  logic reset_n;
  logic [3:0] fn_list_mode;
  logic single_advance;
  logic [27:0] pass_total;
  lts_list_type len_sel;
  logic wr_en;
  lts_list_type wr_list;
  logic [6:0] wr_index;
  logic [31:0] wr_data;
  logic wr_last;
  logic trigger;
  logic [7:0] len_out_q;
  lts_point_type out_point_q;
  logic [3:0] out_apply_q;
  logic [6:0] point_index_q;
  logic marker_pulse_q;
  logic busy_q;
  logic done_q;
  logic list_error_q;
  int fails;
  int tests_run;
  int pulses = 0;

  lts_ctl_model ctl (.core_clk(core_clk), .wr_en(wr_en), .wr_list(wr_list),
    .wr_index(wr_index), .wr_data(wr_data), .wr_last(wr_last), .trigger(trigger));

  lts_sequencer #(.TICK_CYCLES(4)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .wr_en(wr_en), .wr_list(wr_list), .wr_index(wr_index), .wr_data(wr_data),
    .wr_last(wr_last), .len_sel(len_sel), .len_out_q(len_out_q),
    .fn_list_mode(fn_list_mode), .single_advance(single_advance),
    .pass_total(pass_total), .trigger(trigger), .out_point_q(out_point_q),
    .out_apply_q(out_apply_q), .point_index_q(point_index_q),
    .marker_pulse_q(marker_pulse_q), .busy_q(busy_q), .done_q(done_q),
    .list_error_q(list_error_q));

  always #50 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (marker_pulse_q === 1'b1) pulses <= pulses + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic results();
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cyc(1);
    chk(busy_q, 0);
    chk(done_q, 0);
    chk(point_index_q, 0);
  endtask : t_reset

  // Auto pacing with a repeat on point 0: per pass 0,0,1,2 at 5-cycle spacing
  task automatic t_auto();
    int p0;
    int idx;
    ctl.put_list(LST_FREQ, 3, 32'h0a, 32'h14, 32'h1e);
    ctl.put_list(LST_DWELL, 1, 32'h1, 32'h0, 32'h0);
    ctl.put_list(LST_REPEAT, 3, 32'h1, 32'h0, 32'h0);
    ctl.put_list(LST_MARKER, 3, 32'h1, 32'h0, 32'h1);
    @(posedge core_clk);
    fn_list_mode <= 4'h1;
    pass_total <= 28'h2;
    len_sel <= LST_FREQ;
    cyc(2);
    chk(len_out_q, 3);
    p0 = pulses;
    ctl.trig();
    cyc(2);
    for (int k = 0; k < 8; k++) begin
      idx = (k % 4 == 0) ? 0 : (k % 4) - 1;
      chk(point_index_q, idx);
      chk(out_point_q.freq, 32'h0a * (idx + 1));
      if (k < 7) cyc(5);
    end
    cyc(2);
    chk(done_q, 0);
    cyc(1);
    chk(done_q, 1);
    chk(busy_q, 0);
    chk(out_point_q.freq, 32'h1e);
    chk(out_apply_q, 4'h1);
    chk(out_point_q.volt, 16'h0000);
    chk(pulses - p0, 6);
  endtask : t_auto

  // Mismatched slew length refused, single-point slew then stands for all
  task automatic t_err_abort();
    ctl.put_list(LST_SLEW, 2, 32'h5, 32'h6, 32'h0);
    @(posedge core_clk);
    fn_list_mode <= 4'h3;
    pass_total <= 28'h1;
    ctl.trig();
    cyc(1);
    chk(list_error_q, 1);
    chk(busy_q, 0);
    ctl.put_list(LST_SLEW, 1, 32'hffffffff, 32'h0, 32'h0);
    ctl.trig();
    cyc(2);
    chk(list_error_q, 0);
    chk(out_apply_q, 4'h3);
    cyc(10);
    chk(point_index_q, 1);
    chk(out_point_q.slew, 32'hffffffff);
    ctl.put(LST_FREQ, 7'h0, 32'h0a, 1'b0);
    cyc(1);
    chk(busy_q, 0);
    chk(done_q, 0);
    chk(point_index_q, 1);
  endtask : t_err_abort

  // Second trigger lands inside the first dwell and must be dropped
  task automatic t_single();
    ctl.put(LST_REPEAT, 7'h0, 32'h0, 1'b0);
    @(posedge core_clk);
    fn_list_mode <= 4'h1;
    single_advance <= 1'b1;
    ctl.trig();
    ctl.trig();
    cyc(6);
    chk(point_index_q, 0);
    for (int k = 1; k < 3; k++) begin
      ctl.trig();
      cyc(2);
      chk(point_index_q, k);
      chk(out_point_q.freq, 32'h0a * (k + 1));
      cyc(6);
    end
  endtask : t_single

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    fn_list_mode = 4'h0;
    single_advance = 1'b0;
    pass_total = 28'h1;
    len_sel = LST_FREQ;
    fails = 0;
    tests_run = 0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_auto();
    t_err_abort();
    t_single();
    results();
  end

  // Whole run needs under 150 cycles; this margin only catches hangs
  initial begin
    cyc(4000);
    fails++;
    results();
  end
endmodule : lts_sequencer_tb_top
`default_nettype wire
